// ===== hw/cma_pkg.sv
/*
  shared constants and types of the core memory addressing block.
  assumes a single instruction clock and an external instruction decoder.
*/
package cma_pkg;
  // ==========================================================
  // program space
  localparam int PC_W = 15;
  localparam int PM_W = 13;
  localparam logic [14:0] RST_VEC = 15'h0000;
  localparam logic [14:0] IRQ_VEC = 15'h0004;
  localparam logic [12:0] PM_LAST = 13'h1fff;
  // ==========================================================
  // return stack
  localparam int STK_DEPTH = 16;
  localparam logic [4:0] STK_FULL = 5'h10;
  // ==========================================================
  // data space
  localparam int DA_W = 12;
  localparam logic [6:0] CORE_N = 7'h0c;
  localparam logic [6:0] F_IND0 = 7'h00;
  localparam logic [6:0] F_IND1 = 7'h01;
  localparam logic [3:0] F_PCL = 4'h2;
  localparam logic [3:0] F_STATUS = 4'h3;
  localparam logic [3:0] F_P0L = 4'h4;
  localparam logic [3:0] F_P0H = 4'h5;
  localparam logic [3:0] F_P1L = 4'h6;
  localparam logic [3:0] F_P1H = 4'h7;
  localparam logic [3:0] F_BSR = 4'h8;
  localparam logic [3:0] F_WORKING_REGISTER = 4'h9;
  localparam logic [3:0] F_PROGRAM_COUNTER_LATCH_HIGH = 4'ha;
  localparam logic [3:0] F_INTERRUPT_CONTROL_REGISTER = 4'hb;
  localparam logic [6:0] GPR_LO = 7'h20;
  localparam logic [6:0] COMMON_LO = 7'h70;
  localparam logic [11:0] LIN_BYTES = 12'h050;
  localparam logic [11:0] LIN_TOP = 12'ha00;
  localparam logic [3:0] LIN_SEG = 4'h2;
  localparam int PM_SEL_BIT = 15;
  // status flag layout inside the low three bits
  localparam int FL_C = 0;
  localparam int FL_DC = 1;
  localparam int FL_Z = 2;
  localparam logic [7:0] REG_RST = 8'h00;

  typedef enum logic [2:0] {
    PC_NEXT = 3'b000, PC_HOLD = 3'b001, PC_JUMP = 3'b010, PC_CALL = 3'b011,
    PC_RET = 3'b100, PC_IRQ = 3'b101, PC_RETFIE = 3'b110
  } cma_pcop_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_DRD = 2'b01, ST_PRD1 = 2'b10, ST_PRD2 = 2'b11
  } cma_st_t;

  typedef enum logic [1:0] {
    TGT_NONE = 2'b00, TGT_CORE = 2'b01, TGT_DMEM = 2'b10, TGT_PROG = 2'b11
  } cma_tgt_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } cma_freq_t;

  typedef struct packed {
    logic sub;
    logic [2:0] mask;
    logic [7:0] a;
    logic [7:0] b;
  } cma_alu_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } cma_dreq_t;
endpackage : cma_pkg

// ===== hw/cma_stack.sv
/*
  sixteen-entry return address stack with overflow and underflow events.
  assumes push and pop never arrive in the same cycle.
*/
`timescale 1ns/1ns
module cma_stack
  import cma_pkg::*;
(
  input wire logic core_clk,
  input wire logic clr,
  input wire logic push,
  input wire logic pop,
  input wire logic [14:0] push_data,
  output logic [14:0] top,
  output logic ovf_evt,
  output logic unf_evt
);
  logic [14:0] mem_q [STK_DEPTH];
  logic [4:0] cnt_q;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;

  // ==========================================================
  // pointer and events
  assign wr_idx = cnt_q[3:0];
  assign rd_idx = 4'(cnt_q - 5'h01);
  assign ovf_evt = push && cnt_q == STK_FULL;
  assign unf_evt = pop && cnt_q == 5'h00;
  assign top = (cnt_q == 5'h00) ? RST_VEC : mem_q[rd_idx];

  // depth counter, a push on a full stack is dropped
  always_ff @(posedge core_clk) begin
    if (clr) begin
      cnt_q <= 5'h00;
    end else if (push && !ovf_evt) begin
      cnt_q <= cnt_q + 5'h01;
    end else if (pop && !unf_evt) begin
      cnt_q <= cnt_q - 5'h01;
    end
  end

  // entry storage, fifteen bits each
  always_ff @(posedge core_clk) begin
    if (push && !ovf_evt) begin
      mem_q[wr_idx] <= push_data;
    end
  end

  chk_stk_lifo: assert property (@(posedge core_clk) disable iff (clr)
    push && !ovf_evt ##1 pop |-> top == $past(push_data))
    else $error("stack pop does not return last push");
  chk_stk_bound: assert property (@(posedge core_clk) disable iff (clr)
    cnt_q <= STK_FULL)
    else $error("stack depth beyond sixteen");
endmodule : cma_stack

// ===== hw/cma_core.sv
/*
  program counter, return stack, banked and indirect data addressing,
  status flags and interrupt shadow copies of an 8-bit core.
  assumes an external decoder issuing one file access per idle cycle,
  a synchronous data memory answering in the cycle of its request and
  a table port of program memory answering one cycle after its address.
*/
// How it works
// - return addresses in sixteen-entry fifteen-bit stack
// - stack overflow or underflow sets sticky flag
// - stack error triggers soft reset when enabled
// - two sixteen-bit pointers reach all memory
// - program reads through pointers take extra cycle
// - fifteen-bit counter over 32K fourteen-bit words
// - program addresses wrap inside 8192 words
// - reset starts at zero, interrupt at four
// - pointer high bit seven selects program memory
// - pointer program read returns low byte
// - writes to program memory through pointers ignored
// - data memory is 32 banks of 128
// - bank holds core, peripheral, ram, common
// - bank select register chooses direct bank
// - unimplemented data locations read as zero
// - pointers see general ram as linear region
// - flag-updating writes keep ALU flags instead
// - timeout and powerdown flags not instruction writable
// - subtraction carries are inverted borrows
// - interrupt saves and restores core registers except interrupt control
// - subtraction adds two's complement of operand
`timescale 1ns/1ns
module cma_core
  import cma_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire cma_pcop_t pc_op,
  input wire logic [14:0] jump_tgt,
  output logic [12:0] prog_addr,
  input wire cma_freq_t file_req,
  input wire cma_alu_t alu,
  output logic [7:0] alu_result,
  output logic busy,
  output logic [7:0] file_rdata_q,
  output logic file_rvalid_q,
  output cma_dreq_t dmem_req_q,
  input wire logic [7:0] dmem_rdata,
  input wire logic dmem_impl,
  output logic [12:0] tbl_addr_q,
  input wire logic [13:0] tbl_data,
  input wire logic stk_rst_en,
  input wire logic clr_ovf,
  input wire logic clr_unf,
  input wire logic wdt_tmo,
  input wire logic wdt_clear,
  input wire logic sleep_enter,
  output logic stk_ovf_q,
  output logic stk_unf_q,
  output logic soft_rst_q
);
  logic [14:0] pc_q;
  logic [15:0] ptr0_q, ptr1_q;
  logic [4:0] bsr_q;
  logic [7:0] w_q, interrupt_control_register_q;
  logic [6:0] program_counter_latch_high_q;
  logic [2:0] zdc_q;
  logic to_q, pd_q;
  logic [2:0] sh_zdc_q;
  logic [4:0] sh_bsr_q;
  logic [7:0] sh_w_q;
  logic [6:0] sh_program_counter_latch_high_q;
  logic [15:0] sh_p0_q, sh_p1_q;
  cma_st_t state_q;
  cma_tgt_t kind, rsrc_q;
  logic [3:0] coff, roff_q;
  logic [11:0] daddr;
  logic [15:0] ptr;
  logic [11:0] lidx;
  logic [14:0] stk_top;
  logic ovf_evt, unf_evt, rst_all, take_rd, take_wr, wr_core, pcl_wr;
  logic [8:0] sum;
  logic [4:0] nib;
  logic [2:0] alu_f;
  logic [7:0] core_val;

  // ==========================================================
  // address mapping helper
  // common ram folds onto bank zero so every bank sees one copy
  function automatic logic [11:0] cma_map(input logic [4:0] bank, input logic [6:0] off);
    cma_map = (off >= COMMON_LO) ? {5'h00, off} : {bank, off};
  endfunction : cma_map

  assign rst_all = sys_rst | soft_rst_q;
  assign prog_addr = pc_q[12:0] & PM_LAST;

  // ==========================================================
  // alu flags, subtraction adds the two's complement
  always_comb begin
    sum = {1'b0, alu.a} + {1'b0, alu.sub ? ~alu.b : alu.b} + {8'h00, alu.sub};
    nib = {1'b0, alu.a[3:0]} + {1'b0, alu.sub ? ~alu.b[3:0] : alu.b[3:0]}
        + {4'h0, alu.sub};
    alu_f[FL_C] = sum[8];
    alu_f[FL_DC] = nib[4];
    alu_f[FL_Z] = sum[7:0] == 8'h00;
  end
  assign alu_result = sum[7:0];

  // ==========================================================
  // target decode for direct and indirect accesses
  assign ptr = file_req.addr[0] ? ptr1_q : ptr0_q;
  assign lidx = ptr[11:0];
  always_comb begin
    kind = TGT_NONE;
    coff = 4'h0;
    daddr = 12'h000;
    if (file_req.addr > F_IND1) begin
      if (file_req.addr < CORE_N) begin
        kind = TGT_CORE;
        coff = file_req.addr[3:0];
      end else begin
        kind = TGT_DMEM;
        daddr = cma_map(bsr_q, file_req.addr);
      end
    end else if (ptr[PM_SEL_BIT]) begin
      kind = TGT_PROG;
    end else if (ptr[15:12] == 4'h0) begin
      if (ptr[6:0] >= CORE_N) begin
        kind = TGT_DMEM;
        daddr = cma_map(ptr[11:7], ptr[6:0]);
      end else if (ptr[6:0] > F_IND1) begin
        kind = TGT_CORE;
        coff = ptr[3:0];
      end
    end else if (ptr[15:12] == LIN_SEG && lidx < LIN_TOP) begin
      kind = TGT_DMEM;
      daddr = cma_map(5'(lidx / LIN_BYTES), 7'(lidx % LIN_BYTES) + GPR_LO);
    end
  end

  assign busy = state_q != ST_IDLE;
  assign take_rd = file_req.rd && !busy;
  assign take_wr = file_req.wr && !busy && !file_req.rd;
  assign wr_core = take_wr && kind == TGT_CORE;
  assign pcl_wr = wr_core && coff == F_PCL;

  // ==========================================================
  // read sequencer
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (take_rd) begin
            state_q <= (kind == TGT_PROG) ? ST_PRD1 : ST_DRD;
          end
        end
        ST_DRD: state_q <= ST_IDLE;
        ST_PRD1: state_q <= ST_PRD2;
        ST_PRD2: state_q <= ST_IDLE;
      endcase
    end
  end

  // latched source of a pending read and the table address
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      rsrc_q <= TGT_NONE;
      roff_q <= 4'h0;
      tbl_addr_q <= 13'h0000;
    end else if (take_rd) begin
      rsrc_q <= kind;
      roff_q <= coff;
      tbl_addr_q <= ptr[12:0] & PM_LAST;
    end
  end

  // data memory request, program targets never reach it
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      dmem_req_q <= '0;
    end else begin
      dmem_req_q.rd <= take_rd && kind == TGT_DMEM;
      dmem_req_q.wr <= take_wr && kind == TGT_DMEM;
      dmem_req_q.addr <= daddr;
      dmem_req_q.wdata <= file_req.wdata;
    end
  end

  // core register read view
  always_comb begin
    unique case (roff_q)
      F_PCL: core_val = pc_q[7:0];
      F_STATUS: core_val = {3'b000, to_q, pd_q, zdc_q};
      F_P0L: core_val = ptr0_q[7:0];
      F_P0H: core_val = ptr0_q[15:8];
      F_P1L: core_val = ptr1_q[7:0];
      F_P1H: core_val = ptr1_q[15:8];
      F_BSR: core_val = {3'b000, bsr_q};
      F_WORKING_REGISTER: core_val = w_q;
      F_PROGRAM_COUNTER_LATCH_HIGH: core_val = {1'b0, program_counter_latch_high_q};
      F_INTERRUPT_CONTROL_REGISTER: core_val = interrupt_control_register_q;
      default: core_val = 8'h00;
    endcase
  end

  // read data capture and valid pulse
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      file_rdata_q <= 8'h00;
      file_rvalid_q <= 1'b0;
    end else begin
      file_rvalid_q <= state_q == ST_DRD || state_q == ST_PRD2;
      if (state_q == ST_PRD2) begin
        file_rdata_q <= tbl_data[7:0];
      end else if (state_q == ST_DRD) begin
        if (rsrc_q == TGT_CORE) begin
          file_rdata_q <= core_val;
        end else if (rsrc_q == TGT_DMEM && dmem_impl) begin
          file_rdata_q <= dmem_rdata;
        end else begin
          file_rdata_q <= 8'h00;
        end
      end
    end
  end

  // ==========================================================
  // program counter and stack
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      pc_q <= RST_VEC;
    end else if (pc_op == PC_IRQ) begin
      pc_q <= IRQ_VEC;
    end else if (pc_op == PC_RET || pc_op == PC_RETFIE) begin
      pc_q <= stk_top;
    end else if (pc_op == PC_JUMP || pc_op == PC_CALL) begin
      pc_q <= jump_tgt;
    end else if (pcl_wr) begin
      pc_q <= {program_counter_latch_high_q, file_req.wdata};
    end else if (pc_op == PC_NEXT && !busy) begin
      pc_q <= pc_q + 15'h0001;
    end
  end

  cma_stack u_stack (
    .core_clk(core_clk),
    .clr(rst_all),
    .push(pc_op == PC_CALL || pc_op == PC_IRQ),
    .pop(pc_op == PC_RET || pc_op == PC_RETFIE),
    .push_data(pc_op == PC_CALL ? pc_q + 15'h0001 : pc_q),
    .top(stk_top),
    .ovf_evt(ovf_evt),
    .unf_evt(unf_evt)
  );

  // sticky stack error flags, a new event beats a clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stk_ovf_q <= 1'b0;
      stk_unf_q <= 1'b0;
    end else begin
      stk_ovf_q <= ovf_evt | (stk_ovf_q & ~clr_ovf);
      stk_unf_q <= unf_evt | (stk_unf_q & ~clr_unf);
    end
  end

  // one-cycle soft reset on a stack error
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= stk_rst_en && (ovf_evt || unf_evt);
    end
  end

  // ==========================================================
  // core registers, return from interrupt restores shadows
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      ptr0_q <= 16'h0000;
      ptr1_q <= 16'h0000;
      bsr_q <= 5'h00;
      w_q <= REG_RST;
      program_counter_latch_high_q <= 7'h00;
      interrupt_control_register_q <= REG_RST;
    end else if (pc_op == PC_RETFIE) begin
      ptr0_q <= sh_p0_q;
      ptr1_q <= sh_p1_q;
      bsr_q <= sh_bsr_q;
      w_q <= sh_w_q;
      program_counter_latch_high_q <= sh_program_counter_latch_high_q;
    end else if (wr_core) begin
      unique case (coff)
        F_P0L: ptr0_q[7:0] <= file_req.wdata;
        F_P0H: ptr0_q[15:8] <= file_req.wdata;
        F_P1L: ptr1_q[7:0] <= file_req.wdata;
        F_P1H: ptr1_q[15:8] <= file_req.wdata;
        F_BSR: bsr_q <= file_req.wdata[4:0];
        F_WORKING_REGISTER: w_q <= file_req.wdata;
        F_PROGRAM_COUNTER_LATCH_HIGH: program_counter_latch_high_q <= file_req.wdata[6:0];
        F_INTERRUPT_CONTROL_REGISTER: interrupt_control_register_q <= file_req.wdata;
        default: ;
      endcase
    end
  end

  // shadow copies taken on interrupt entry
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      sh_zdc_q <= 3'b000;
      sh_bsr_q <= 5'h00;
      sh_w_q <= REG_RST;
      sh_program_counter_latch_high_q <= 7'h00;
      sh_p0_q <= 16'h0000;
      sh_p1_q <= 16'h0000;
    end else if (pc_op == PC_IRQ) begin
      sh_zdc_q <= zdc_q;
      sh_bsr_q <= bsr_q;
      sh_w_q <= w_q;
      sh_program_counter_latch_high_q <= program_counter_latch_high_q;
      sh_p0_q <= ptr0_q;
      sh_p1_q <= ptr1_q;
    end
  end

  // arithmetic flags, an affecting instruction blocks the write
  always_ff @(posedge core_clk) begin
    if (rst_all) begin
      zdc_q <= 3'b000;
    end else if (pc_op == PC_RETFIE) begin
      zdc_q <= sh_zdc_q;
    end else if (alu.mask != 3'b000) begin
      zdc_q <= (alu.mask & alu_f) | (~alu.mask & zdc_q);
    end else if (wr_core && coff == F_STATUS) begin
      zdc_q <= file_req.wdata[2:0];
    end
  end

  // timeout and powerdown follow only watchdog and sleep events
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end else if (wdt_tmo) begin
      to_q <= 1'b0;
    end else if (wdt_clear) begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end else if (sleep_enter) begin
      to_q <= 1'b1;
      pd_q <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  chk_irq_vector: assert property (!soft_rst_q && pc_op == PC_IRQ |=> pc_q == IRQ_VEC)
    else $error("interrupt did not jump to vector four");
  chk_ovf_sticky: assert property (ovf_evt |=> stk_ovf_q)
    else $error("overflow flag not set");
  chk_err_reset: assert property (
    stk_rst_en && unf_evt && !soft_rst_q |=> soft_rst_q ##1 pc_q == RST_VEC)
    else $error("stack error did not reset");
  chk_prog_extra: assert property (
    take_rd && kind == TGT_PROG |=> busy [*2] ##1 file_rvalid_q)
    else $error("program read not one cycle longer");
  chk_prog_byte: assert property (state_q == ST_PRD2 |=> file_rdata_q == $past(tbl_data[7:0]))
    else $error("program read byte wrong");
  chk_prog_ro: assert property (take_wr && kind == TGT_PROG |=> !dmem_req_q.wr)
    else $error("program write leaked to data memory");
  chk_unimpl_zero: assert property (
    state_q == ST_DRD && rsrc_q == TGT_NONE |=> file_rdata_q == 8'h00)
    else $error("unimplemented read not zero");
  chk_status_protect: assert property (
    !soft_rst_q && pc_op != PC_RETFIE && alu.mask == 3'b111 |=> zdc_q == $past(alu_f))
    else $error("status write overrode alu flags");
  chk_to_pd_fixed: assert property (
    !wdt_tmo && !wdt_clear && !sleep_enter |=> $stable(to_q) && $stable(pd_q))
    else $error("timeout or powerdown changed by write");
  chk_sub_borrow: assert property (
    alu.sub && alu.a >= alu.b |-> alu_f[FL_C])
    else $error("no borrow not shown as carry set");
  chk_shadow_back: assert property (
    !soft_rst_q && pc_op == PC_RETFIE |=> w_q == $past(sh_w_q) && bsr_q == $past(sh_bsr_q))
    else $error("shadow restore failed");

  cov_prog_read: cover property (take_rd && kind == TGT_PROG ##3 file_rvalid_q);
  cov_linear: cover property (take_rd && ptr[15:12] == LIN_SEG && kind == TGT_DMEM);
  cov_overflow: cover property (ovf_evt && stk_rst_en);
endmodule : cma_core

// ===== verif/cma_mem_model.sv
/*
  partner model: banked data memory and program table port of the core.
  assumes registered requests from the core, all on core_clk.
*/
`timescale 1ns/1ns
module cma_mem_model
  import cma_pkg::*;
(
  input wire logic core_clk,
  input wire cma_dreq_t dmem_req_q,
  output logic [7:0] dmem_rdata,
  output logic dmem_impl,
  input wire logic [12:0] tbl_addr_q,
  output logic [13:0] tbl_data
);
  // ==========================================================
  // data storage
  logic [7:0] mem_q [0:4095]; // 32 banks of 128 bytes
  logic [7:0] last_q;

  // filled with a pattern so stale reads are not all zero
  initial begin
    for (int k = 0; k < 4096; k++) begin
      mem_q[k] = k[7:0] ^ 8'h3c;
    end
    last_q = 8'h00;
  end

  // writes land on the edge after the pulse, reads remember their data
  always @(posedge core_clk) begin
    if (dmem_req_q.wr) begin
      mem_q[dmem_req_q.addr] <= dmem_req_q.wdata;
    end
    if (dmem_req_q.rd) begin
      last_q <= mem_q[dmem_req_q.addr];
    end
  end

  // peripheral offsets are not backed here and answer as unimplemented
  assign dmem_impl = dmem_req_q.rd && (dmem_req_q.addr[6:0] >= 7'h20);
  // outside a read the bus shows inverted stale data, never a clean value
  assign dmem_rdata = dmem_req_q.rd ? mem_q[dmem_req_q.addr] : ~last_q;

  // ==========================================================
  // program table: 14-bit words over 8192 addresses, one cycle late
  always @(posedge core_clk) begin
    tbl_data <= {1'b1, tbl_addr_q ^ 13'h0a5c};
  end
endmodule : cma_mem_model

// ===== verif/cma_core_test.sv
/*
  self-checking bench of cma_core, random stimulus with corner cases.
  assumes cma_pkg and cma_mem_model are compiled before this file.
*/
`timescale 1ns/1ns
module cma_core_test
  import cma_pkg::*;
;
  // ==========================================================
  // signals
  logic core_clk, sys_rst, stk_rst_en, clr_ovf, clr_unf, wdt_tmo, wdt_clear;
  logic sleep_enter, busy, file_rvalid_q, dmem_impl, stk_ovf_q, stk_unf_q, soft_rst_q;
  cma_pcop_t pc_op;
  logic [14:0] jump_tgt, pcv, t;
  logic [12:0] prog_addr, tbl_addr_q;
  cma_freq_t file_req;
  cma_alu_t alu;
  cma_dreq_t dmem_req_q;
  logic [7:0] alu_result, file_rdata_q, dmem_rdata, d, e;
  logic [13:0] tbl_data;
  logic [31:0] r;
  logic [8:0] s9;
  logic bz;
  logic [4:0] s5, bank;
  logic [6:0] off;
  logic [15:0] p;
  logic [14:0] ret_q [$];
  int err_count = 0, cmp_count = 0, seed = 89, cyc = 0, n, i, idx;

  // ==========================================================
  // design and partner
  cma_core DUT (.core_clk(core_clk), .sys_rst(sys_rst), .pc_op(pc_op), .jump_tgt(jump_tgt),
    .prog_addr(prog_addr), .file_req(file_req), .alu(alu), .alu_result(alu_result),
    .busy(busy), .file_rdata_q(file_rdata_q), .file_rvalid_q(file_rvalid_q),
    .dmem_req_q(dmem_req_q), .dmem_rdata(dmem_rdata), .dmem_impl(dmem_impl),
    .tbl_addr_q(tbl_addr_q), .tbl_data(tbl_data), .stk_rst_en(stk_rst_en),
    .clr_ovf(clr_ovf), .clr_unf(clr_unf), .wdt_tmo(wdt_tmo), .wdt_clear(wdt_clear),
    .sleep_enter(sleep_enter), .stk_ovf_q(stk_ovf_q), .stk_unf_q(stk_unf_q),
    .soft_rst_q(soft_rst_q));
  cma_mem_model u_mem (.core_clk(core_clk), .dmem_req_q(dmem_req_q),
    .dmem_rdata(dmem_rdata), .dmem_impl(dmem_impl), .tbl_addr_q(tbl_addr_q),
    .tbl_data(tbl_data));

  // ==========================================================
  // clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      $display("Error at %0t: run did not finish in time", $time);
      results();
    end
  end

  // ==========================================================
  // helpers: compare, step, pc op, file write, file read
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick
  task automatic pc(input cma_pcop_t op, input logic [14:0] tg);
    pc_op = op;
    jump_tgt = tg;
    @(posedge core_clk);
    pc_op <= PC_HOLD; // released on the sampling edge, so the next call may set it
    #1;
  endtask : pc
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    file_req = {1'b0, 1'b1, a, v};
    @(posedge core_clk);
    file_req <= '0;
    #1;
  endtask : wr
  task automatic rd(input logic [6:0] a);
    file_req = {1'b1, 1'b0, a, 8'h00};
    @(posedge core_clk);
    file_req <= '0;
    #1;
    bz = busy;
    n = 1;
    while (file_rvalid_q !== 1'b1 && n < 6) begin
      tick();
      n++;
    end
    d = file_rdata_q;
  endtask : rd
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // ==========================================================
  // main sequence
  initial begin
    {sys_rst, stk_rst_en, clr_ovf, clr_unf, wdt_tmo, wdt_clear, sleep_enter} = 7'h40;
    pc_op = PC_HOLD;
    jump_tgt = '0;
    file_req = '0;
    alu = '0;
    repeat (3) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    chk(prog_addr === 13'h0000, "reset vector");
    rd({3'h0, F_STATUS});
    chk(d === 8'h18, "status after reset");
    // counter wraps inside the implemented space
    pc(PC_JUMP, 15'h7ffe);
    chk(prog_addr === 13'h1ffe, "jump high");
    pc_op = PC_NEXT;
    tick();
    chk(prog_addr === 13'h1fff, "last address");
    tick();
    chk(prog_addr === 13'h0000, "wrap to zero");
    // seventeen calls overflow the sixteen-entry stack
    pc(PC_JUMP, 15'h0100);
    pcv = 15'h0100;
    for (i = 0; i < 17; i++) begin
      r = $random(seed);
      if (i < 16) ret_q.push_back(pcv + 15'h0001);
      pcv = r[14:0];
      pc(PC_CALL, pcv);
      chk(prog_addr === pcv[12:0], "call target");
    end
    repeat (2) tick();
    chk(stk_ovf_q === 1'b1 && stk_unf_q === 1'b0, "overflow flag");
    for (i = 0; i < 16; i++) begin
      t = ret_q.pop_back();
      pc(PC_RET, 15'h0000);
      chk(prog_addr === t[12:0], "return address");
    end
    pc(PC_RET, 15'h0000);
    repeat (2) tick();
    chk(stk_unf_q === 1'b1, "underflow flag");
    {clr_ovf, clr_unf} = 2'b11;
    tick();
    {clr_ovf, clr_unf} = 2'b00;
    tick();
    chk(stk_ovf_q === 1'b0 && stk_unf_q === 1'b0, "flags cleared");
    // stack error with reset option enabled
    stk_rst_en = 1'b1;
    pc(PC_JUMP, 15'h0123);
    pc(PC_RET, 15'h0000);
    i = 0;
    while (soft_rst_q !== 1'b1 && i < 4) begin
      tick();
      i++;
    end
    chk(soft_rst_q === 1'b1, "soft reset pulse");
    tick();
    chk(prog_addr === 13'h0000 && stk_unf_q === 1'b1, "restart at zero");
    stk_rst_en = 1'b0;
    tick();
    // flag-updating writes to status, add and subtract
    for (i = 0; i < 6; i++) begin
      r = $random(seed);
      alu = {i[0], 3'b111, r[7:0], (i < 2) ? r[7:0] : r[15:8]};
      s9 = {1'b0, alu.a} + {1'b0, alu.sub ? ~alu.b : alu.b} + {8'h00, alu.sub};
      s5 = {1'b0, alu.a[3:0]} + {1'b0, alu.sub ? ~alu.b[3:0] : alu.b[3:0]} + {4'h0, alu.sub};
      wr({3'h0, F_STATUS}, 8'hff);
      chk(alu_result === s9[7:0], "alu result");
      alu = '0;
      rd({3'h0, F_STATUS});
      chk(d === {5'b00011, s9[7:0] == 8'h00, s5[4], s9[8]}, "alu flags");
    end
    wr({3'h0, F_STATUS}, 8'hff);
    rd({3'h0, F_STATUS});
    chk(d === 8'h1f, "status write kept out of upper bits");
    sleep_enter = 1'b1;
    tick();
    sleep_enter = 1'b0;
    rd({3'h0, F_STATUS});
    chk(d[4:3] === 2'b10, "powerdown on sleep");
    // a write cannot raise powerdown, only watchdog and sleep events move the pair
    wr({3'h0, F_STATUS}, 8'hff);
    wdt_tmo = 1'b1;
    tick();
    wdt_tmo = 1'b0;
    rd({3'h0, F_STATUS});
    chk(d[4:3] === 2'b00, "timeout with powerdown kept");
    wdt_clear = 1'b1;
    tick();
    wdt_clear = 1'b0;
    wr({3'h0, F_STATUS}, 8'h00);
    rd({3'h0, F_STATUS});
    chk(d[4:3] === 2'b11, "timeout and powerdown not writable");
    // direct banked access, common area folds to bank zero
    for (i = 0; i < 6; i++) begin
      r = $random(seed);
      bank = r[4:0];
      off = (i == 0) ? 7'h7a : 7'(32 + r[15:8] % 80);
      wr({3'h0, F_BSR}, {3'h0, bank});
      wr({3'h0, F_WORKING_REGISTER}, r[31:24]);
      rd({3'h0, F_WORKING_REGISTER});
      chk(d === r[31:24], "core register in bank");
      wr(off, r[23:16]);
      chk(dmem_req_q.addr === {(off >= 7'h70) ? 5'h00 : bank, off}, "direct addr");
      rd(off);
      chk(d === r[23:16] && n == 2, "direct read back");
    end
    wr(7'h15, 8'hff);
    rd(7'h15);
    chk(d === 8'h00, "unimplemented reads zero");
    // linear window through pointer 0, top index as corner
    for (i = 0; i < 6; i++) begin
      r = $random(seed);
      idx = (i == 0) ? 2559 : r[11:0] % 2560;
      p = 16'h2000 + 16'(idx);
      wr({3'h0, F_P0L}, p[7:0]);
      wr({3'h0, F_P0H}, p[15:8]);
      wr({3'h0, F_IND0}, r[23:16]);
      chk(dmem_req_q.addr === {5'(idx / 80), 7'(32 + idx % 80)}, "linear addr");
      rd({3'h0, F_IND0});
      chk(d === r[23:16], "linear read back");
    end
    // pointer outside every region, then a pointer onto a core register
    wr({3'h0, F_P0H}, 8'h30);
    wr({3'h0, F_IND0}, 8'h77);
    chk(dmem_req_q.wr === 1'b0, "unmapped pointer write ignored");
    rd({3'h0, F_IND0});
    chk(d === 8'h00, "unmapped pointer reads zero");
    wr({3'h0, F_WORKING_REGISTER}, 8'h6e);
    wr({3'h0, F_P0H}, 8'h00);
    wr({3'h0, F_P0L}, 8'h89);
    rd({3'h0, F_IND0});
    chk(d === 8'h6e, "pointer reaches core register");
    // program memory through pointer 1: extra cycle, low byte, no writes
    for (i = 0; i < 4; i++) begin
      r = $random(seed);
      t = r[14:0];
      wr({3'h0, F_P1L}, t[7:0]);
      wr({3'h0, F_P1H}, {1'b1, t[14:8]});
      rd({3'h0, F_IND1});
      chk(tbl_addr_q === t[12:0], "table address");
      chk(d === (t[7:0] ^ 8'h5c), "program low byte");
      chk(n == 3, "program read latency");
      chk(bz === 1'b1, "busy during program read");
      wr({3'h0, F_IND1}, r[23:16]);
      chk(dmem_req_q.wr === 1'b0, "program write ignored");
    end
    // counter low write, then a call returned at once
    wr({3'h0, F_PROGRAM_COUNTER_LATCH_HIGH}, 8'h12);
    wr({3'h0, F_PCL}, 8'h34);
    chk(prog_addr === 13'h1234, "counter low write");
    pc(PC_JUMP, 15'h0020);
    pc(PC_CALL, 15'h0300);
    pc(PC_RET, 15'h0000);
    chk(prog_addr === 13'h0021, "call then return");
    // interrupt entry and return restore context
    wr({3'h0, F_WORKING_REGISTER}, 8'h5a);
    wr({3'h0, F_BSR}, 8'h03);
    pc(PC_JUMP, 15'h0040);
    pc(PC_IRQ, 15'h0000);
    chk(prog_addr === 13'h0004, "interrupt vector");
    wr({3'h0, F_WORKING_REGISTER}, 8'ha5);
    wr({3'h0, F_BSR}, 8'h1f);
    pc(PC_RETFIE, 15'h0000);
    chk(prog_addr === 13'h0040, "interrupt return");
    rd({3'h0, F_WORKING_REGISTER});
    chk(d === 8'h5a, "working register restored");
    rd({3'h0, F_BSR});
    chk(d === 8'h03, "bank select restored");
    results();
  end
endmodule : cma_core_test
